//--- adc_spi_cfg.svh
// Constants for the converter serial readout port
`ifndef ADC_SPI_CFG_SVH
`define ADC_SPI_CFG_SVH

`define ADC_CLK_MHZ      250
`define ADC_TIMEOUT_MS   28
`define ADC_TIMEOUT_CYC  (`ADC_TIMEOUT_MS * `ADC_CLK_MHZ * 1000)
`define ADC_SHORT_BITS   16
`define ADC_LONG_BITS    32
`define ADC_CFG_RESET    16'h058b
`define ADC_CFG_SS       15
`define ADC_CFG_MUX_HI   14
`define ADC_CFG_MUX_LO   12
`define ADC_CFG_PGA_HI   11
`define ADC_CFG_PGA_LO   9
`define ADC_CFG_MODE     8
`define ADC_CFG_DR_HI    7
`define ADC_CFG_DR_LO    5
`define ADC_CFG_TS       4
`define ADC_CFG_PULLUP   3
`define ADC_CFG_NOP_HI   2
`define ADC_CFG_NOP_LO   1
`define ADC_CFG_RSVD     0
`define ADC_NOP_VALID    2'b01
`define ADC_PIN_RESET    3'b001

`endif

//--- adc_spi_pkg.sv
// Types shared by the converter serial readout port
`default_nettype none
package adc_spi_pkg;
    typedef enum logic [1:0] {
        XFER_IDLE    = 2'b00,
        XFER_ACTIVE  = 2'b01,
        XFER_TIMEOUT = 2'b10
    } xfer_state_t;

    typedef enum logic [2:0] {
        analog_input_zero  = 3'b000,
        analog_input_one   = 3'b001,
        analog_input_two   = 3'b010,
        analog_input_three = 3'b011,
        ground_ref         = 3'b100
    } mux_input_t;
endpackage
`default_nettype wire

//--- adc_result_fifo.sv
// Two-entry result buffer with valid and ready on both sides
`default_nettype none
module adc_result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
        ptrInc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // Handshake terms
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = CW'(count_r + 1'b1);
        end else if (pop && !push) begin
            count_nxt = CW'(count_r - 1'b1);
        end
    end

    // Storage and pointers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_r   <= '{default: '0};
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            inReady <= 1'b0; // Not ready until reset is gone
        end else begin
            if (push) begin
                mem_r[wrPtr_r] <= inData;
                wrPtr_r        <= ptrInc(wrPtr_r);
            end
            if (pop) begin
                rdPtr_r <= ptrInc(rdPtr_r);
            end
            count_r <= count_nxt;
            inReady <= (count_nxt != CW'(DEPTH)); // Registered not-full
        end
    end
endmodule
`default_nettype wire

//--- adc_spi_readout.sv
// Serial readout and configuration port of a small converter
//
// Function
// - Raising select resets the serial state and drops partial transfers.
// - Next select low shifts out the buffered result from the first rising edge.
// - Ready low at start means a new result; high repeats the last one.
// - Mode 1: clock idles low, output changes only on rising edges.
// - Both sides sample incoming data on falling clock edges.
// - Deselected, the data/ready pin is weakly pulled to supply by default.
// - With pull-up bit clear, the pin floats while select is high.
// - No ready pulse appears while select is high.
// - At select low, pin drives low if new result unread, else high.
// - A result finishing mid-transfer waits for a later transfer.
// - Result holding register stays stable so any readout is complete.
// - Clock low longer than 28 ms abandons the transfer.
// - Mux measures each input against ground, input 0 against input 1, or inputs 0-2 against input 3.
// - Mode 0 converts continuously; mode 1 starts on a written start bit.
// - Config updates only when the write-valid bits are 01.
// - Result bit 15 comes first; config bits are taken on falling edges.
// - A transfer is 16 bits, or 32 bits with config readback.
`include "adc_spi_cfg.svh"
`default_nettype none
module adc_spi_readout #(
    parameter int RESULT_BITS    = `ADC_SHORT_BITS,
    parameter int BUF_DEPTH      = 2,
    parameter int TIMEOUT_CYCLES = `ADC_TIMEOUT_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    selectN,
    input  wire logic                    serialClk,
    input  wire logic                    serialIn,
    output logic                         serialOutReadyN,
    output logic                         serialOutEnN,
    output logic                         weakPullUp,
    input  wire logic [RESULT_BITS-1:0]  convData,
    input  wire logic                    convValid,
    output logic                         convReady,
    output logic                         convContinuous,
    output logic                         convStart,
    output adc_spi_pkg::mux_input_t      muxPos,
    output adc_spi_pkg::mux_input_t      muxNeg,
    output logic [2:0]                   gainSel,
    output logic [2:0]                   rateSel,
    output logic                         tempMode
);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

    logic [2:0]               pinS1_r;
    logic [2:0]               pinS2_r;
    logic [2:0]               pinS3_r;
    logic [2:0]               pinClean_r;
    logic [2:0]               pinPrev_r;
    logic                     csRise;
    logic                     csFall;
    logic                     sclkRise;
    logic                     sclkFall;
    adc_spi_pkg::xfer_state_t state_r;
    logic [31:0]              shiftOut_r;
    logic [15:0]              cfgShift_r;
    logic [15:0]              cfg_r;
    logic [15:0]              cfgWord;
    logic                     cfgApply;
    logic [5:0]               riseCnt_r;
    logic [5:0]               fallCnt_r;
    logic [TW-1:0]            toCnt_r;
    logic [RESULT_BITS-1:0]   result_r;
    logic                     newData_r;
    logic [RESULT_BITS-1:0]   bufData;
    logic                     bufValid;
    logic                     bufPop;
    logic [5:0]               muxPair;

    // Mux code to positive and negative input
    function automatic logic [5:0] muxDecode(input logic [2:0] code);
        case (code)
            3'b000:  muxDecode = {adc_spi_pkg::analog_input_zero, adc_spi_pkg::analog_input_one};
            3'b001:  muxDecode = {adc_spi_pkg::analog_input_zero, adc_spi_pkg::analog_input_three};
            3'b010:  muxDecode = {adc_spi_pkg::analog_input_one, adc_spi_pkg::analog_input_three};
            3'b011:  muxDecode = {adc_spi_pkg::analog_input_two, adc_spi_pkg::analog_input_three};
            3'b100:  muxDecode = {adc_spi_pkg::analog_input_zero, adc_spi_pkg::ground_ref};
            3'b101:  muxDecode = {adc_spi_pkg::analog_input_one, adc_spi_pkg::ground_ref};
            3'b110:  muxDecode = {adc_spi_pkg::analog_input_two, adc_spi_pkg::ground_ref};
            default: muxDecode = {adc_spi_pkg::analog_input_three, adc_spi_pkg::ground_ref};
        endcase
    endfunction

    // Pin synchronisers, bits are {din, sclk, select}
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinS1_r    <= `ADC_PIN_RESET;
            pinS2_r    <= `ADC_PIN_RESET;
            pinS3_r    <= `ADC_PIN_RESET;
            pinClean_r <= `ADC_PIN_RESET;
            pinPrev_r  <= `ADC_PIN_RESET;
        end else begin
            pinS1_r   <= {serialIn, serialClk, selectN};
            pinS2_r   <= pinS1_r;
            pinS3_r   <= pinS2_r;
            pinPrev_r <= pinClean_r;
            for (int i = 0; i < 3; i++) begin
                if (pinS2_r[i] == pinS3_r[i]) begin
                    pinClean_r[i] <= pinS3_r[i];
                end
            end
        end
    end

    // Edge events on the cleaned pins
    assign csFall   = pinPrev_r[0] && !pinClean_r[0];
    assign csRise   = !pinPrev_r[0] && pinClean_r[0];
    assign sclkRise = !pinPrev_r[1] && pinClean_r[1];
    assign sclkFall = pinPrev_r[1] && !pinClean_r[1];

    // Buffer holds finished conversions until select is high
    assign bufPop = (state_r == adc_spi_pkg::XFER_IDLE) && pinClean_r[0] && !csFall;

    adc_result_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (BUF_DEPTH)
    ) resultBuf (
        .clk      (clk),
        .reset    (reset),
        .inData   (convData),
        .inValid  (convValid),
        .inReady  (convReady), // Flop inside the buffer, same edge as its take
        .outData  (bufData),
        .outValid (bufValid),
        .outReady (bufPop)
    );

    // Result holding register and new-data flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_r  <= '0;
            newData_r <= 1'b0;
        end else begin
            if (bufValid && bufPop) begin
                result_r  <= bufData;
                newData_r <= 1'b1;
            end else if (state_r == adc_spi_pkg::XFER_ACTIVE && sclkRise
                         && riseCnt_r == '0) begin
                newData_r <= 1'b0;
            end
        end
    end

    // Transfer state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= adc_spi_pkg::XFER_IDLE;
        end else begin
            case (state_r)
                adc_spi_pkg::XFER_IDLE: begin
                    if (csFall) begin
                        state_r <= adc_spi_pkg::XFER_ACTIVE;
                    end
                end
                adc_spi_pkg::XFER_ACTIVE: begin
                    if (pinClean_r[0]) begin
                        state_r <= adc_spi_pkg::XFER_IDLE;
                    end else if (toCnt_r == TW'(TIMEOUT_CYCLES)) begin
                        state_r <= adc_spi_pkg::XFER_TIMEOUT;
                    end
                end
                default: begin
                    if (pinClean_r[0]) begin
                        state_r <= adc_spi_pkg::XFER_IDLE;
                    end
                end
            endcase
        end
    end

    // Clock-low watchdog
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            toCnt_r <= '0;
        end else if (state_r != adc_spi_pkg::XFER_ACTIVE || pinClean_r[1] || sclkFall) begin
            toCnt_r <= '0;
        end else if (toCnt_r != TW'(TIMEOUT_CYCLES)) begin
            toCnt_r <= TW'(toCnt_r + 1'b1);
        end
    end

    // Output shifter, launched on rising edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shiftOut_r <= '0;
            riseCnt_r  <= '0;
        end else if (csFall) begin
            shiftOut_r <= {result_r, cfg_r};
            riseCnt_r  <= '0;
        end else if (state_r != adc_spi_pkg::XFER_ACTIVE) begin
            riseCnt_r  <= '0;
        end else if (sclkRise) begin
            shiftOut_r <= {shiftOut_r[30:0], 1'b0};
            if (riseCnt_r != 6'(`ADC_LONG_BITS)) begin
                riseCnt_r <= 6'(riseCnt_r + 1'b1);
            end
        end
    end

    // Pin drive: ready level at select low, data on rising edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serialOutReadyN <= 1'b1;
            serialOutEnN    <= 1'b1;
            weakPullUp      <= 1'b1;
        end else begin
            weakPullUp <= pinClean_r[0] && cfg_r[`ADC_CFG_PULLUP];
            if (csFall) begin
                serialOutEnN    <= 1'b0;
                serialOutReadyN <= !newData_r;
            end else if (state_r == adc_spi_pkg::XFER_IDLE || pinClean_r[0]) begin
                serialOutEnN    <= 1'b1;
                serialOutReadyN <= 1'b1;
            end else if (state_r == adc_spi_pkg::XFER_TIMEOUT) begin
                serialOutReadyN <= 1'b1;
            end else if (sclkRise) begin
                serialOutReadyN <= shiftOut_r[31];
            end
        end
    end

    // Config word completes on the sixteenth falling edge
    assign cfgWord  = {cfgShift_r[14:0], pinClean_r[2]};
    assign cfgApply = (state_r == adc_spi_pkg::XFER_ACTIVE) && !pinClean_r[0] && sclkFall
                      && fallCnt_r == 6'(`ADC_SHORT_BITS - 1);

    // Input shifter, sampled on falling edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfgShift_r <= '0;
            fallCnt_r  <= '0;
        end else if (state_r != adc_spi_pkg::XFER_ACTIVE) begin
            fallCnt_r  <= '0;
        end else if (sclkFall) begin
            cfgShift_r <= cfgWord;
            if (fallCnt_r != 6'(`ADC_LONG_BITS)) begin
                fallCnt_r <= 6'(fallCnt_r + 1'b1);
            end
        end
    end

    // Configuration register and conversion control
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_r     <= `ADC_CFG_RESET;
            convStart <= 1'b0;
        end else begin
            convStart <= 1'b0;
            if (cfgApply && cfgWord[`ADC_CFG_NOP_HI:`ADC_CFG_NOP_LO] == `ADC_NOP_VALID) begin
                cfg_r     <= {1'b0, cfgWord[14:1], 1'b1};
                convStart <= cfgWord[`ADC_CFG_SS] && cfgWord[`ADC_CFG_MODE];
            end
        end
    end

    // Decoded configuration outputs
    assign muxPair = muxDecode(cfg_r[`ADC_CFG_MUX_HI:`ADC_CFG_MUX_LO]);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            muxPos         <= adc_spi_pkg::analog_input_zero;
            muxNeg         <= adc_spi_pkg::analog_input_one;
            gainSel        <= '0;
            rateSel        <= '0;
            tempMode       <= 1'b0;
            convContinuous <= 1'b0;
        end else begin
            muxPos           <= adc_spi_pkg::mux_input_t'(muxPair[5:3]);
            muxNeg           <= adc_spi_pkg::mux_input_t'(muxPair[2:0]);
            gainSel          <= cfg_r[`ADC_CFG_PGA_HI:`ADC_CFG_PGA_LO];
            rateSel          <= cfg_r[`ADC_CFG_DR_HI:`ADC_CFG_DR_LO];
            tempMode         <= cfg_r[`ADC_CFG_TS];
            convContinuous   <= !cfg_r[`ADC_CFG_MODE];
        end
    end

    // Checks on the port behaviour
    select_release_a: assert property (@(posedge clk) disable iff (reset)
        csRise |=> serialOutEnN ##1 serialOutEnN)
        else $error("pin still driven after select rose");
    ready_level_a: assert property (@(posedge clk) disable iff (reset)
        csFall |=> !serialOutEnN && serialOutReadyN == !$past(newData_r))
        else $error("ready level at select low wrong");
    first_bit_a: assert property (@(posedge clk) disable iff (reset)
        state_r == adc_spi_pkg::XFER_ACTIVE && sclkRise && riseCnt_r == '0 && !pinClean_r[0]
        |=> serialOutReadyN == result_r[RESULT_BITS-1])
        else $error("first bit is not result msb");
    flag_clear_a: assert property (@(posedge clk) disable iff (reset)
        state_r == adc_spi_pkg::XFER_ACTIVE && sclkRise && riseCnt_r == '0 |=> !newData_r)
        else $error("new-data flag not cleared");
    result_hold_a: assert property (@(posedge clk) disable iff (reset)
        state_r != adc_spi_pkg::XFER_IDLE |=> $stable(result_r))
        else $error("result changed during transfer");
    nop_ignore_a: assert property (@(posedge clk) disable iff (reset)
        cfgApply && cfgWord[2:1] != 2'b01 |=> $stable(cfg_r))
        else $error("config changed on no-op word");
    clock_timeout_a: assert property (@(posedge clk) disable iff (reset)
        state_r == adc_spi_pkg::XFER_ACTIVE && !pinClean_r[0] && toCnt_r == TW'(TIMEOUT_CYCLES)
        |=> state_r == adc_spi_pkg::XFER_TIMEOUT)
        else $error("timeout not taken");
    select_reset_a: assert property (@(posedge clk) disable iff (reset)
        csRise |=> ##1 state_r == adc_spi_pkg::XFER_IDLE && riseCnt_r == '0)
        else $error("serial state not reset by select");
    common_point_a: assert property (@(posedge clk) disable iff (reset)
        cfg_r[14:12] == 3'b011 |=> muxPos == adc_spi_pkg::analog_input_two
        && muxNeg == adc_spi_pkg::analog_input_three)
        else $error("mux pairing wrong");
    free_run_a: assert property (@(posedge clk) disable iff (reset)
        !cfg_r[`ADC_CFG_MODE] && !cfgApply |=> convContinuous && !convStart)
        else $error("continuous mode not signalled");
endmodule
`default_nettype wire

//--- adc_spi_host_model.sv
// Behavioural mode 1 serial host that drives the converter's select, clock and data pins
`default_nettype none
module adc_spi_host_model #(
    parameter int HALF_CYC = 12
) (
    input  wire logic clk,
    output logic      selectN,
    output logic      serialClk,
    output logic      serialIn,
    input  wire logic pinLevel
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle pin levels: deselected, clock low
    initial begin
        selectN   = 1'b1;
        serialClk = 1'b0;
        serialIn  = 1'b0;
    end

    // Wait whole cycles, then step just past the edge
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Own select line per device, then look at the ready level
    task automatic select_low(output logic rdy);
        selectN = 1'b0;
        idle(HALF_CYC);
        rdy = pinLevel;
    endtask

    // One clock pulse: data launched on the rise, sampled on the fall
    task automatic pulse(input logic din, input int lowHold, output logic dout);
        serialClk = 1'b1;
        serialIn  = din;
        idle(HALF_CYC);
        dout      = pinLevel;
        serialClk = 1'b0;
        idle(lowHold);
    endtask

    // Release select and let the device see it high
    task automatic deselect();
        selectN  = 1'b1;
        serialIn = ~serialIn;
        idle(2 * HALF_CYC);
    endtask

    // Full transfer; a long clock-low gap follows bit gapAt when it is not negative
    task automatic transfer(input int nBits, input logic [15:0] cfg, input int gapAt,
                            output logic rdy, output logic [31:0] rx);
        logic b;
        select_low(rdy);
        rx = 32'h0;
        for (int i = 0; i < nBits; i++) begin
            pulse((i < 16) ? cfg[15-i] : 1'b0, (i == gapAt) ? 260 : HALF_CYC, b);
            rx = {rx[30:0], b};
        end
        deselect();
    endtask
endmodule
`default_nettype wire

//--- adc_spi_readout_tb.sv
// Self-checking bench for the converter serial readout port
`default_nettype none
module adc_spi_readout_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        reset;
    logic        selectN;
    logic        serialClk;
    logic        serialIn;
    logic        serialOutReadyN;
    logic        serialOutEnN;
    logic        weakPullUp;
    logic [15:0] convData;
    logic        convValid;
    logic        convReady;
    logic        convContinuous;
    logic        convStart;
    adc_spi_pkg::mux_input_t muxPos;
    adc_spi_pkg::mux_input_t muxNeg;
    logic [2:0]  gainSel;
    logic [2:0]  rateSel;
    logic        tempMode;
    wire         pinLevel;
    logic        rdy;
    logic [31:0] rx;
    int          errorCnt;
    int          totalChecks;
    int          startCnt;
    int          selHigh;
    logic        drvWhileHigh;

    // Shared data/ready wire: driven, weakly pulled up, or floating
    assign pinLevel = (serialOutEnN == 1'b0) ? serialOutReadyN : (weakPullUp ? 1'b1 : 1'bz);

    adc_spi_readout #(.TIMEOUT_CYCLES(200)) dut (
        .clk(clk), .reset(reset), .selectN(selectN), .serialClk(serialClk),
        .serialIn(serialIn), .serialOutReadyN(serialOutReadyN), .serialOutEnN(serialOutEnN),
        .weakPullUp(weakPullUp), .convData(convData), .convValid(convValid),
        .convReady(convReady), .convContinuous(convContinuous), .convStart(convStart),
        .muxPos(muxPos), .muxNeg(muxNeg), .gainSel(gainSel), .rateSel(rateSel),
        .tempMode(tempMode)
    );

    adc_spi_host_model host (
        .clk(clk), .selectN(selectN), .serialClk(serialClk), .serialIn(serialIn),
        .pinLevel(pinLevel)
    );

    // Clock at 250 MHz
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // Start pulses and any drive on the pin while select has settled high
    always @(posedge clk) begin
        if (convStart === 1'b1) startCnt++;
        selHigh = (selectN === 1'b1) ? selHigh + 1 : 0;
        if (selHigh > 8 && serialOutEnN !== 1'b1) drvWhileHigh = 1'b1;
    end

    // Compare one value and count the outcome
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Hand one conversion word over with valid held until ready is seen
    task automatic push(input logic [15:0] w);
        int n;
        n = 0;
        convData  = w;
        convValid = 1'b1;
        while (convReady !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        tick(1);
        convValid = 1'b0;
        convData  = ~w;
        if (n >= 100) check("conv handshake", 32'h1, 32'h0);
    endtask

    task automatic xfer(input int n, input logic [15:0] cfg, input int gap);
        host.transfer(n, cfg, gap, rdy, rx);
    endtask

    // Expected {positive, negative} input for a mux code
    function automatic logic [5:0] mux_exp(input logic [2:0] c);
        if (c[2]) return {1'b0, c[1:0], 3'h4};
        return (c == 3'h0) ? 6'h01 : {1'b0, c[1:0] - 2'h1, 3'h3};
    endfunction

    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        errorCnt++;
        wrapUp();
    end

    // Main sequence
    initial begin
        errorCnt = 0; totalChecks = 0; startCnt = 0; selHigh = 0; drvWhileHigh = 1'b0;
        reset = 1'b1; convData = 16'h0; convValid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("pull-up in reset", 32'(weakPullUp), 32'h1);
        check("enable in reset", 32'(serialOutEnN), 32'h1);
        check("mode in reset", 32'(convContinuous), 32'h0);
        reset = 1'b0;
        tick(10);
        push(16'ha5c3);
        tick(10);
        xfer(16, 16'h0000, -1);
        check("ready new", 32'(rdy), 32'h0);
        check("result first", rx, 32'h0000a5c3);
        xfer(16, 16'h0000, -1);
        check("ready repeat", 32'(rdy), 32'h1);
        check("result repeat", rx, 32'h0000a5c3);
        // Word finishing mid-transfer stays out of it
        fork
            xfer(16, 16'h0000, -1);
            begin tick(60); push(16'h3c5a); end
        join
        check("result mid", rx, 32'h0000a5c3);
        xfer(16, 16'h0000, -1);
        check("ready later", 32'(rdy), 32'h0);
        check("result later", rx, 32'h00003c5a);
        // Partial transfer abandoned by select
        host.select_low(rdy);
        for (int i = 0; i < 5; i++) host.pulse(1'b1, 12, rdy);
        host.deselect();
        xfer(16, 16'h0000, -1);
        check("after partial", rx, 32'h00003c5a);
        // Long transfer writing continuous mode, pull-up off
        xfer(32, 16'h4473, -1);
        check("long result", rx[31:16], 32'h3c5a);
        check("readback", rx[15:0], 32'h058b);
        check("continuous", 32'(convContinuous), 32'h1);
        check("fields", 32'({gainSel, rateSel, tempMode}), 32'h27);
        check("enable off", 32'(serialOutEnN), 32'h1);
        check("pull-up off", 32'(weakPullUp), 32'h0);
        // Invalid write patterns change nothing
        for (int k = 0; k < 4; k++) begin
            if (k == 1) continue;
            xfer(32, 16'h4571 | 16'(k << 1), -1);
            check("nop readback", rx[15:0], 32'h4473);
            check("nop mode", 32'(convContinuous), 32'h1);
        end
        // Every mux code
        for (int c = 0; c < 8; c++) begin
            xfer(16, {1'b0, 3'(c), 12'h473}, -1);
            check("mux", {muxPos, muxNeg}, 32'(mux_exp(3'(c))));
        end
        // Single shot start with pull-up back on
        startCnt = 0;
        xfer(16, 16'hc57b, -1);
        check("start pulses", startCnt, 32'h1);
        check("single shot", 32'(convContinuous), 32'h0);
        check("pull-up on", 32'(weakPullUp), 32'h1);
        // Fill the buffer while the reader is busy
        fork
            xfer(16, 16'h0000, -1);
            begin
                tick(40);
                push(16'h1111);
                tick(1);
                push(16'h2222);
                tick(3);
                check("buffer full", 32'(convReady), 32'h0);
            end
        join
        xfer(16, 16'h0000, -1);
        check("drain ready", 32'(rdy), 32'h0);
        check("drain word", rx, 32'h00002222);
        check("buffer free", 32'(convReady), 32'h1);
        // Clock held low too long mid-transfer
        xfer(16, 16'h0000, 3);
        check("timeout", rx, 32'h00002fff);
        xfer(16, 16'h0000, -1);
        check("after timeout", rx, 32'h00002222);
        check("no drive deselected", 32'(drvWhileHigh), 32'h0);
        wrapUp();
    end
endmodule
`default_nettype wire
